// file: design/upsc_pkg.sv
// constants, field layouts and carrier types of the port switch register bank
package upsc_pkg;
  // serial bus slave address, seven bits
  localparam logic [6:0] I2C_ADDR     = 7'h25;
  // register offsets
  localparam logic [7:0] A_VERSION    = 8'h01;
  localparam logic [7:0] A_CTRL       = 8'h02;
  localparam logic [7:0] A_IRQ        = 8'h03;
  localparam logic [7:0] A_IRQ_MASK   = 8'h05;
  localparam logic [7:0] A_RES_CODE   = 8'h07;
  localparam logic [7:0] A_TIMING     = 8'h08;
  localparam logic [7:0] A_STATUS     = 8'h09;
  localparam logic [7:0] A_PORT_TYPE  = 8'h0a;
  localparam logic [7:0] A_ADC_RAW    = 8'h0b;
  localparam logic [7:0] A_MAN_SW     = 8'h13;
  localparam logic [7:0] A_MAN_CHG    = 8'h14;
  localparam logic [7:0] A_ID_MATCH   = 8'h1b;
  localparam logic [7:0] A_ID_CHECK   = 8'h1c;
  // reset values
  localparam logic [7:0] RST_CTRL     = 8'hd1;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_MAN_SW   = 8'h27;
  localparam logic [7:0] RST_ID_MATCH = 8'h08;
  localparam logic [7:0] RST_ID_CHECK = 8'h05;
  // control bit positions
  localparam int CTRL_TMO   = 7;
  localparam int CTRL_SRST  = 6;
  localparam int CTRL_HOLD  = 5;
  localparam int CTRL_MAN   = 4;
  localparam int CTRL_GMASK = 0;
  // interrupt bit positions
  localparam int IRQ_OCP  = 6;
  localparam int IRQ_OVP  = 5;
  localparam int IRQ_MIC  = 4;
  localparam int IRQ_RES  = 3;
  localparam int IRQ_VBUS = 2;
  localparam int IRQ_DONE = 1;
  localparam logic [7:0] IRQ_USED = 8'h7e;
  // manual charge control bit positions
  localparam int CHG_FORCE = 4;
  localparam int CHG_MICP  = 3;
  localparam int CHG_DPLUS = 2;
  // id measurement time table
  localparam logic [9:0] DET_BASE_MS  = 10'h032;
  localparam logic [9:0] DET_STEP_MS  = 10'h064;
  localparam logic [3:0] DET_MAX_CODE = 4'hb;
  localparam logic [9:0] DET_MAX_MS   = 10'h3e8;
  // live status levels, in status register bit order 7..0
  typedef struct packed {
    logic flag_a;
    logic overcurrent_state;
    logic overvoltage_state;
    logic mic_overvoltage_state;
    logic id_attached_flag;
    logic vbus_valid;
    logic charger_detect_active;
    logic contact_found;
  } upsc_live_t;
  // one-hot connector line routing, all zero means open
  typedef struct packed {
    logic mic;
    logic host2;
    logic audio;
    logic host1;
  } upsc_route_t;
  typedef enum {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} upsc_i2c_st_t;
  typedef enum {P_ADDR, P_PTR, P_DATA} upsc_phase_t;
endpackage

// file: design/upsc_regs.sv
// register bank with serial bus slave for the usb port switch
`timescale 1ns/1ns
`default_nettype none
module upsc_regs
  import upsc_pkg::*;
#(
  parameter logic [4:0] VERSION_ID = 5'h01  // arbitrary version value
) (
  input  wire logic        I_REF_CLK,        // core clock, 50 MHz
  input  wire logic        I_RSTN,           // async reset, active low
  input  wire logic        I_CE,             // clock enable
  input  wire logic        I_SCL,            // bus clock pin
  input  wire logic        I_SDA,            // bus data pin level
  output logic             O_SDA,            // bus data drive value
  output logic             O_SDA_OE,         // bus data drive enable
  input  wire upsc_live_t  I_LIVE,           // live status levels
  input  wire logic        I_CHG_DET_DONE,   // charger detection done pulse
  input  wire logic [4:0]  I_ID_RES_CODE,    // measured resistor code
  input  wire logic [7:0]  I_ID_ADC_RAW,     // raw id conversion
  input  wire logic [3:0]  I_PORT_FLAGS,     // dock, dcp, cdp, sdp
  input  wire logic [7:0]  I_AUTO_SW,        // automatic switch setting
  input  wire logic        I_CHG_AUTO,       // automatic charger assert
  output logic             O_IRQ_OUT_N,      // interrupt, active low
  output logic             O_CONTACT_TIMEOUT_ENABLE, // contact timeout on
  output logic             O_ID_DETECT_HOLD, // id detect hold
  output logic             O_ID_MEASURE_EN,  // id measurement running
  output logic             O_MANUAL_SWITCH_ENABLE, // manual mode
  output logic             O_SOFT_RST,       // soft reset pulse
  output logic [9:0]       O_ID_DET_TIME_MS, // id measurement time, ms
  output logic [3:0]       O_ID_MATCH_NEED,  // matches needed for attach
  output logic [2:0]       O_ID_CHECKS,      // checks for code change
  output logic [1:0]       O_ID_CAP_SEL,     // id capacitance select
  output upsc_route_t      O_DM_ROUTE,       // minus line routing
  output upsc_route_t      O_DP_ROUTE,       // plus line routing
  output logic [1:0]       O_VBUS_SW,        // bus supply switching
  output logic             O_MIC_PROTECT_ENABLE, // mic protection on
  output logic             O_DPLUS_FORCE,    // force plus line level
  output logic             O_CHARGER_ATTACHED_N,    // open drain value
  output logic             O_CHARGER_ATTACHED_N_OE  // open drain enable
);
  logic [1:0]   scl_s, sda_s;
  logic         scl_d, sda_d;
  upsc_i2c_st_t st_r;
  upsc_phase_t  ph_r;
  logic [3:0]   cnt_r;
  logic [7:0]   sh_r, tx_r, ptr_r;
  logic         rw_r, sda_oe_r;
  logic         wr_stb, ld_stb;
  logic [7:0]   ctrl_r, pend_r, mask_r, tim_r, msw_r, mchg_r, app1_r, app2_r;
  logic         soft_rst_r, irq_n_r;
  upsc_live_t   live_d;
  logic [4:0]   code_d;
  logic [7:0]   rd_data, set_v, sel_sw;

  // two flops on each pin before any logic looks at them
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (I_CE) begin
      scl_s <= {scl_s[0], I_SCL};
      sda_s <= {sda_s[0], I_SDA};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire bus_stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // byte complete strobes: a write lands, or a read byte is fetched
  assign wr_stb = scl_fall && st_r == S_RX && cnt_r == 4'h8
                  && ph_r == P_DATA;
  assign ld_stb = scl_fall && ((st_r == S_ACK && rw_r)
                  || st_r == S_MACK);

  // bus slave: bits shift on the clock high, data changes on its fall
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r     <= S_IDLE;
      ph_r     <= P_ADDR;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (I_CE) begin
      if (bus_start) begin
        st_r     <= S_RX;
        ph_r     <= P_ADDR;
        cnt_r    <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
        st_r     <= S_IDLE;
        sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == S_RX) begin
          sh_r  <= {sh_r[6:0], sda_s[1]};
          cnt_r <= cnt_r + 4'h1;
        end else if (st_r == S_TX) begin
          cnt_r <= cnt_r + 4'h1;
        end else if (st_r == S_MACK && sda_s[1]) begin
          st_r <= S_IDLE;                // master nack ends the read
        end
      end else if (scl_fall) begin
        case (st_r)
          S_RX: begin
            if (cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (ph_r == P_ADDR) begin
                if (sh_r[7:1] == I2C_ADDR) begin
                  rw_r     <= sh_r[0];
                  ph_r     <= sh_r[0] ? P_DATA : P_PTR;
                  sda_oe_r <= 1'b1;
                  st_r     <= S_ACK;
                end else begin
                  st_r <= S_IDLE;        // not ours, stay off the bus
                end
              end else begin
                if (ph_r == P_PTR) begin
                  ptr_r <= sh_r;
                end else begin
                  ptr_r <= ptr_r + 8'h01;
                end
                ph_r     <= P_DATA;
                sda_oe_r <= 1'b1;
                st_r     <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (rw_r) begin
              tx_r     <= {rd_data[6:0], 1'b0};
              sda_oe_r <= ~rd_data[7];
              ptr_r    <= ptr_r + 8'h01;
              st_r     <= S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              st_r     <= S_RX;
            end
          end
          S_TX: begin
            if (cnt_r == 4'h8) begin
              cnt_r    <= 4'h0;
              sda_oe_r <= 1'b0;
              st_r     <= S_MACK;
            end else begin
              sda_oe_r <= ~tx_r[7];
              tx_r     <= {tx_r[6:0], 1'b0};
            end
          end
          S_MACK: begin
            tx_r     <= {rd_data[6:0], 1'b0};
            sda_oe_r <= ~rd_data[7];
            ptr_r    <= ptr_r + 8'h01;
            st_r     <= S_TX;
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  assign O_SDA    = 1'b0;
  assign O_SDA_OE = sda_oe_r;

  // read mux; reserved bits read zero and the reset bit always reads one
  always_comb begin
    case (ptr_r)
      A_VERSION:   rd_data = {VERSION_ID, 3'h0};
      A_CTRL:      rd_data = ctrl_r | (8'h01 << CTRL_SRST);
      A_IRQ:       rd_data = pend_r;
      A_IRQ_MASK:  rd_data = mask_r;
      A_RES_CODE:  rd_data = {3'h0, I_ID_RES_CODE};
      A_TIMING:    rd_data = tim_r;
      A_STATUS:    rd_data = I_LIVE;
      A_PORT_TYPE: rd_data = {2'h0, I_PORT_FLAGS[3], 2'h0,
                              I_PORT_FLAGS[2:0]};
      A_ADC_RAW:   rd_data = I_ID_ADC_RAW;
      A_MAN_SW:    rd_data = msw_r;
      A_MAN_CHG:   rd_data = mchg_r;
      A_ID_MATCH:  rd_data = app1_r;
      A_ID_CHECK:  rd_data = app2_r;
      default:     rd_data = 8'h00;
    endcase
  end

  // registers kept across a soft reset
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_r     <= RST_CTRL & ~(8'h01 << CTRL_SRST);
      msw_r      <= RST_MAN_SW;
      mchg_r     <= RST_ZERO;
      soft_rst_r <= 1'b0;
    end else if (I_CE) begin
      soft_rst_r <= wr_stb && ptr_r == A_CTRL && !sh_r[CTRL_SRST];
      if (wr_stb && ptr_r == A_CTRL) begin
        ctrl_r <= sh_r & 8'hb1;
      end
      if (wr_stb && ptr_r == A_MAN_SW) begin
        msw_r <= sh_r;
      end
      if (wr_stb && ptr_r == A_MAN_CHG) begin
        mchg_r <= sh_r & 8'h1c;
      end
    end
  end

  // registers that the soft reset returns to defaults
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mask_r <= RST_ZERO;
      tim_r  <= RST_ZERO;
      app1_r <= RST_ID_MATCH;
      app2_r <= RST_ID_CHECK;
    end else if (I_CE) begin
      if (soft_rst_r) begin
        mask_r <= RST_ZERO;
        tim_r  <= RST_ZERO;
        app1_r <= RST_ID_MATCH;
        app2_r <= RST_ID_CHECK;
      end else if (wr_stb) begin
        if (ptr_r == A_IRQ_MASK) mask_r <= sh_r & IRQ_USED;
        if (ptr_r == A_TIMING) tim_r <= sh_r & 8'h0f;
        if (ptr_r == A_ID_MATCH) app1_r <= sh_r & 8'h1c;
        if (ptr_r == A_ID_CHECK) app2_r <= sh_r & 8'h0f;
      end
    end
  end

  // change events; code change is dropped entirely under hold
  always_comb begin
    set_v           = 8'h00;
    set_v[IRQ_OCP]  = live_d.overcurrent_state != I_LIVE.overcurrent_state;
    set_v[IRQ_OVP]  = live_d.overvoltage_state != I_LIVE.overvoltage_state;
    set_v[IRQ_MIC]  = live_d.mic_overvoltage_state
                      != I_LIVE.mic_overvoltage_state;
    set_v[IRQ_RES]  = code_d != I_ID_RES_CODE && !ctrl_r[CTRL_HOLD];
    set_v[IRQ_VBUS] = live_d.vbus_valid != I_LIVE.vbus_valid;
    set_v[IRQ_DONE] = I_CHG_DET_DONE;
  end

  // sticky flags; a fetch of this register clears, a new event wins
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pend_r  <= RST_ZERO;
      live_d  <= '0;
      code_d  <= 5'h00;
      irq_n_r <= 1'b1;
    end else if (I_CE) begin
      live_d <= I_LIVE;
      code_d <= I_ID_RES_CODE;
      if (soft_rst_r) begin
        pend_r <= RST_ZERO;
      end else if (ld_stb && ptr_r == A_IRQ) begin
        pend_r <= set_v;
      end else begin
        pend_r <= pend_r | set_v;
      end
      irq_n_r <= !(|(pend_r & ~mask_r & IRQ_USED)
                   && !ctrl_r[CTRL_GMASK]);
    end
  end

  assign O_IRQ_OUT_N = irq_n_r;

  // switch source and routing decode
  assign sel_sw = ctrl_r[CTRL_MAN] ? msw_r : I_AUTO_SW;
  always_comb begin
    O_DM_ROUTE = '0;
    O_DP_ROUTE = '0;
    case (sel_sw[7:5])
      3'h1:    O_DM_ROUTE.host1 = 1'b1;
      3'h2:    O_DM_ROUTE.audio = 1'b1;
      3'h3:    O_DM_ROUTE.host2 = 1'b1;
      default: O_DM_ROUTE = '0;
    endcase
    case (sel_sw[4:2])
      3'h1:    O_DP_ROUTE.host1 = 1'b1;
      3'h2:    O_DP_ROUTE.audio = 1'b1;
      3'h3:    O_DP_ROUTE.host2 = 1'b1;
      3'h4:    O_DP_ROUTE.mic = 1'b1;
      default: O_DP_ROUTE = '0;
    endcase
  end
  assign O_VBUS_SW = sel_sw[1:0];

  // measurement time table; undefined codes clamp to the longest
  always_comb begin
    if (tim_r[3:0] > DET_MAX_CODE) begin
      O_ID_DET_TIME_MS = DET_MAX_MS;
    end else if (tim_r[3:0] < 4'h4) begin
      O_ID_DET_TIME_MS = DET_BASE_MS * ({6'h00, tim_r[3:0]} + 10'h001);
    end else begin
      O_ID_DET_TIME_MS = DET_STEP_MS * ({6'h00, tim_r[3:0]} - 10'h001);
    end
  end

  // configuration outputs
  assign O_CONTACT_TIMEOUT_ENABLE = ctrl_r[CTRL_TMO];
  assign O_ID_DETECT_HOLD = ctrl_r[CTRL_HOLD];
  assign O_ID_MEASURE_EN = !(ctrl_r[CTRL_HOLD]
                             && I_LIVE.id_attached_flag);
  assign O_MANUAL_SWITCH_ENABLE = ctrl_r[CTRL_MAN];
  assign O_SOFT_RST = soft_rst_r;
  assign O_ID_MATCH_NEED = {1'b0, app1_r[4:2]} + 4'h1;
  assign O_ID_CHECKS = {1'b0, app2_r[3:2]} + 3'h1;
  assign O_ID_CAP_SEL = app2_r[1:0];
  assign O_MIC_PROTECT_ENABLE = mchg_r[CHG_MICP];
  assign O_DPLUS_FORCE = mchg_r[CHG_DPLUS] && I_LIVE.vbus_valid;
  assign O_CHARGER_ATTACHED_N = 1'b0;
  assign O_CHARGER_ATTACHED_N_OE = mchg_r[CHG_FORCE] || I_CHG_AUTO;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_srst_write;
    I_CE && wr_stb && ptr_r == A_CTRL && !sh_r[CTRL_SRST];
  endsequence
  sequence s_one_pulse;
    O_SOFT_RST ##1 !O_SOFT_RST;
  endsequence
  a_srst_pulse: assert property (s_srst_write |=> s_one_pulse)
    else $error("soft reset pulse wrong");
  a_srst_mask: assert property (O_SOFT_RST && I_CE |=> mask_r == 8'h00)
    else $error("mask not reset by soft reset");
  a_irq_gmask: assert property (ctrl_r[CTRL_GMASK]
    && $past(ctrl_r[CTRL_GMASK]) |-> O_IRQ_OUT_N)
    else $error("interrupt signalled under global mask");
  a_irq_raise: assert property (I_CE && |(pend_r & ~mask_r & IRQ_USED)
    && !ctrl_r[CTRL_GMASK] |=> !O_IRQ_OUT_N)
    else $error("interrupt not raised");
  a_irq_masked: assert property (I_CE && (pend_r & ~mask_r & IRQ_USED) == 0
    |=> O_IRQ_OUT_N)
    else $error("masked source signalled");
  a_ocp_flag: assert property (I_CE && !soft_rst_r
    && live_d.overcurrent_state != I_LIVE.overcurrent_state
    |=> pend_r[IRQ_OCP])
    else $error("over current change lost");
  a_code_float: assert property (I_CE && !soft_rst_r && !ctrl_r[CTRL_HOLD]
    && code_d != 5'h00 && I_ID_RES_CODE == 5'h00 |=> pend_r[IRQ_RES])
    else $error("float change not flagged");
  a_code_hold: assert property (I_CE && ctrl_r[CTRL_HOLD] && !pend_r[IRQ_RES]
    |=> !pend_r[IRQ_RES])
    else $error("code change flagged under hold");
  a_time_ends: assert property ((tim_r[3:0] == 4'h0 |-> O_ID_DET_TIME_MS
    == 10'd50) and (tim_r[3:0] == 4'hb |-> O_ID_DET_TIME_MS == 10'd1000))
    else $error("measurement time decode wrong");
  a_match_need: assert property (app1_r[4:2] == 3'h7
    |-> O_ID_MATCH_NEED == 4'h8)
    else $error("match count decode wrong");
  a_auto_route: assert property (!O_MANUAL_SWITCH_ENABLE
    && I_AUTO_SW[4:2] == 3'h0 |-> O_DP_ROUTE == '0)
    else $error("manual setting used in automatic mode");
endmodule
`default_nettype wire

// file: test/upsc_host.sv
// serial bus master model standing in for the host processor
`timescale 1ns/1ns
`default_nettype none
module upsc_host
  import upsc_pkg::*;
(
  input  wire logic i_clk,      // core clock, paces the bus
  input  wire logic i_sda,      // resolved data wire, pulled up
  output logic      o_scl,      // bus clock, stands high between frames
  output logic      o_sda_pull  // high pulls the data wire low
);
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // a quarter of the 160 ns bus period is two core cycles
  task automatic qtr();
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // data changes mid-low, sampled mid-high so the slave's sync has settled
  task automatic bit_io(input logic b, output logic r);
    qtr();
    o_sda_pull = ~b;
    qtr();
    o_scl = 1'b1;
    qtr();
    r = i_sda;
    qtr();
    o_scl = 1'b0;
  endtask
  // serves both a first and a repeated start
  task automatic start_c();
    qtr();
    o_sda_pull = 1'b0;
    qtr();
    o_scl = 1'b1;
    qtr();
    o_sda_pull = 1'b1;
    qtr();
    o_scl = 1'b0;
  endtask
  task automatic stop_c();
    qtr();
    o_sda_pull = 1'b1;
    qtr();
    o_scl = 1'b1;
    qtr();
    o_sda_pull = 1'b0;
    qtr();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, d,
                    output logic ack);
    logic k0, k1, k2;
    start_c();
    send({dev, 1'b0}, k0);
    send(a, k1);
    send(d, k2);
    stop_c();
    ack = k0 & k1 & k2;
  endtask
  // pointer write, repeated start, one byte, nack ends the read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k, r;
    start_c();
    send({I2C_ADDR, 1'b0}, k);
    send(a, k);
    start_c();
    send({I2C_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_c();
  endtask
endmodule
`default_nettype wire

// file: test/usb_port_switch_control_regs_tb.sv
// self-checking bench for the port switch register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp, msg) begin n_checks++; if ((act) !== (exp)) begin \
  error_cnt++; $display("wrong value at %0t ns: %s", $time, msg); end end
module usb_port_switch_control_regs_tb
  import upsc_pkg::*;
;
  logic clk, rstn, pull, done, chg_auto, ack, scl;
  logic irq_n, tmo_en, hold, meas_en, man_en, srst, sda_oe;
  logic ce, sda_o, mic_en, dp_force, chg_oe, chg_n;
  logic [2:0] id_checks;
  logic [1:0] cap_sel;
  logic [4:0] code;
  logic [7:0] adc, auto_sw;
  logic [3:0] pflags, match_need;
  logic [9:0] det_ms;
  logic [1:0] vbus_sw;
  upsc_live_t live;
  upsc_route_t dm_rt, dp_rt;
  wire sda_w;
  int error_cnt = 0;
  int n_checks = 0;
  int srst_cnt = 0;
  // arbitrary version value; unmapped 0x04 closes the table
  logic [7:0] ra [14] = '{A_VERSION, A_CTRL, A_IRQ, A_IRQ_MASK, A_RES_CODE,
    A_TIMING, A_STATUS, A_PORT_TYPE, A_ADC_RAW, A_MAN_SW, A_MAN_CHG,
    A_ID_MATCH, A_ID_CHECK, 8'h04};
  logic [7:0] rv [14] = '{8'h48, 8'hd1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h27, 8'h00, 8'h08, 8'h05, 8'h00};
  // open drain: either party pulling wins over the pull-up
  assign sda_w = ~((sda_oe && !sda_o) || pull);
  upsc_regs #(.VERSION_ID(5'h09)) dut_u (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_SCL(scl),
    .I_SDA(sda_w), .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_LIVE(live),
    .I_CHG_DET_DONE(done), .I_ID_RES_CODE(code), .I_ID_ADC_RAW(adc),
    .I_PORT_FLAGS(pflags), .I_AUTO_SW(auto_sw), .I_CHG_AUTO(chg_auto),
    .O_IRQ_OUT_N(irq_n), .O_CONTACT_TIMEOUT_ENABLE(tmo_en),
    .O_ID_DETECT_HOLD(hold), .O_ID_MEASURE_EN(meas_en),
    .O_MANUAL_SWITCH_ENABLE(man_en), .O_SOFT_RST(srst),
    .O_ID_DET_TIME_MS(det_ms), .O_ID_MATCH_NEED(match_need),
    .O_ID_CHECKS(id_checks), .O_ID_CAP_SEL(cap_sel), .O_DM_ROUTE(dm_rt),
    .O_DP_ROUTE(dp_rt), .O_VBUS_SW(vbus_sw),
    .O_MIC_PROTECT_ENABLE(mic_en), .O_DPLUS_FORCE(dp_force),
    .O_CHARGER_ATTACHED_N(chg_n), .O_CHARGER_ATTACHED_N_OE(chg_oe));
  upsc_host host_u (.i_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_pull(pull));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // counts soft reset pulses; the pulse lasts one cycle only
  always @(posedge clk) if (srst === 1'b1) srst_cnt++;
  function automatic upsc_route_t rt(input logic [2:0] c);
    rt = '0;
    case (c)
      3'h1: rt.host1 = 1'b1;
      3'h2: rt.audio = 1'b1;
      3'h3: rt.host2 = 1'b1;
      3'h4: rt.mic = 1'b1;
      default: ;
    endcase
  endfunction
  function automatic logic [9:0] det_exp(input int c);
    // codes past the table clamp to the longest time
    return (c > 11) ? 10'd1000 :
           (c < 4) ? 10'(50 * (c + 1)) : 10'(100 * (c - 1));
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.wr(I2C_ADDR, a, d, ack);
    `CHK(ack, 1'b1, "write not acknowledged")
  endtask
  task automatic rd_chk(input logic [7:0] a, exp, input string msg);
    logic [7:0] d;
    host_u.rd(a, d);
    `CHK(d, exp, msg)
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the tests need about 20k cycles; 50k cycles means a hang
  initial begin
    #1000000;
    error_cnt++;
    $display("wrong value at %0t ns: run hung", $time);
    report_and_stop();
  end
  initial begin
    {rstn, done, chg_auto, code, adc, pflags, live} = '0;
    auto_sw = 8'h68;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    step(5);
    for (int i = 0; i < 14; i++) rd_chk(ra[i], rv[i], "reset value");
    `CHK(irq_n, 1'b1, "irq at reset")
    `CHK(id_checks, 3'h2, "id check count")
    `CHK(cap_sel, 2'h1, "id capacitance select")
    $display("test reset done");
    wr(A_CTRL, 8'h40);
    `CHK(tmo_en, 1'b0, "timeout enable")
    `CHK(man_en, 1'b0, "manual enable")
    `CHK(dm_rt, rt(3'h3), "auto minus route")
    `CHK(dp_rt, rt(3'h2), "auto plus route")
    wr(A_CTRL, 8'hd0);
    `CHK(tmo_en, 1'b1, "timeout enable")
    `CHK(dm_rt, rt(3'h1), "manual minus route")
    `CHK(dp_rt, rt(3'h1), "manual plus route")
    `CHK(vbus_sw, 2'b11, "supply switch")
    wr(A_MAN_SW, 8'h00);
    `CHK(dp_rt, rt(3'h0), "open plus route")
    wr(A_MAN_SW, 8'h50);
    `CHK(dm_rt, rt(3'h2), "audio minus route")
    `CHK(dp_rt, rt(3'h4), "mic plus route")
    $display("test switching done");
    for (int c = 0; c < 16; c++) begin
      wr(A_TIMING, 8'(c));
      `CHK(det_ms, det_exp(c), "detection time")
    end
    wr(A_ID_MATCH, 8'h1c);
    `CHK(match_need, 4'h8, "match count")
    wr(A_ID_MATCH, 8'h00);
    `CHK(match_need, 4'h1, "match count")
    $display("test timing done");
    wr(A_CTRL, 8'h40);
    wr(A_IRQ_MASK, 8'h02);
    done = 1'b1;
    step(1);
    done = 1'b0;
    step(3);
    `CHK(irq_n, 1'b1, "masked source signalled")
    ce = 1'b0;
    live = '1;
    step(3);
    `CHK(irq_n, 1'b1, "irq moved while frozen")
    ce = 1'b1;
    step(3);
    `CHK(irq_n, 1'b0, "irq not raised")
    rd_chk(A_STATUS, 8'hff, "status levels");
    wr(A_IRQ, 8'h00);
    rd_chk(A_IRQ, 8'h76, "pending flags");
    `CHK(irq_n, 1'b1, "irq not released")
    rd_chk(A_IRQ, 8'h00, "read did not clear");
    wr(A_CTRL, 8'h41);
    live = '0;
    step(3);
    `CHK(irq_n, 1'b1, "global mask ignored")
    rd_chk(A_IRQ, 8'h74, "pending flags");
    $display("test interrupt done");
    wr(A_CTRL, 8'h40);
    code = 5'h13;
    step(3);
    `CHK(irq_n, 1'b0, "code change irq")
    rd_chk(A_RES_CODE, 8'h13, "resistor code");
    rd_chk(A_IRQ, 8'h08, "code change flag");
    code = 5'h00;
    step(3);
    rd_chk(A_IRQ, 8'h08, "float not flagged");
    wr(A_CTRL, 8'h60);
    code = 5'h07;
    step(3);
    `CHK(irq_n, 1'b1, "held code irq")
    rd_chk(A_IRQ, 8'h00, "held code flag");
    live.id_attached_flag = 1'b1;
    step(2);
    `CHK(hold, 1'b1, "hold output")
    `CHK(meas_en, 1'b0, "measuring under hold")
    $display("test resistor code done");
    pflags = 4'b1010;
    adc = 8'ha7;
    rd_chk(A_PORT_TYPE, 8'h22, "port type");
    pflags = 4'b0101;
    rd_chk(A_PORT_TYPE, 8'h05, "port type");
    rd_chk(A_ADC_RAW, 8'ha7, "raw conversion");
    $display("test port type done");
    wr(A_IRQ_MASK, 8'h3c);
    wr(A_TIMING, 8'h05);
    wr(A_MAN_CHG, 8'h1c);
    `CHK(mic_en, 1'b1, "mic protection enable")
    `CHK({chg_oe, chg_n}, 2'b10, "charger attached drive")
    `CHK(dp_force, 1'b0, "plus force without bus voltage")
    live.vbus_valid = 1'b1;
    step(1);
    `CHK(dp_force, 1'b1, "plus force with bus voltage")
    srst_cnt = 0;
    wr(A_CTRL, 8'h10);
    `CHK(srst_cnt, 1, "soft reset pulses")
    `CHK(man_en, 1'b1, "manual enable kept")
    rd_chk(A_CTRL, 8'h50, "control kept");
    rd_chk(A_IRQ_MASK, 8'h00, "mask reset");
    rd_chk(A_TIMING, 8'h00, "timing reset");
    rd_chk(A_MAN_CHG, 8'h1c, "charge control kept");
    rd_chk(A_MAN_SW, 8'h50, "switch kept");
    wr(A_CTRL, 8'h40);
    host_u.wr(7'h26, A_TIMING, 8'h09, ack);
    `CHK(ack, 1'b0, "foreign address acknowledged")
    rd_chk(A_TIMING, 8'h00, "foreign write landed");
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
